// ==== verilog/input_capture_defs.svh ====
`ifndef INPUT_CAPTURE_DEFS_SVH
`define INPUT_CAPTURE_DEFS_SVH
// Register byte offsets
`define IC_OFF_TSEL_LO 12'h000
`define IC_OFF_TSEL_HI 12'h004
`define IC_OFF_MODE 12'h008
`define IC_OFF_ROUTE 12'h00c
`define IC_OFF_FLAGS 12'h010
`define IC_OFF_MASK 12'h014
`define IC_OFF_CAP0 12'h018
`define IC_CAP_SPAN 12'h004
// Reset values
`define IC_ROUTE_RST 2'h1
// Mode codes of capture_event_mode
`define IC_MODE_FALL 4'h4
`define IC_MODE_RISE 4'h5
`define IC_MODE_RISE4 4'h6
`define IC_MODE_RISE16 4'h7
// Prescale terminal counts
`define IC_PRESC4_END 4'h3
`define IC_PRESC16_END 4'hf
`endif

// ==== verilog/input_capture_pkg.sv ====
package input_capture_pkg;
  // Counts of the three 16-bit time bases
  typedef struct packed {
    logic [15:0] t5;
    logic [15:0] t3;
    logic [15:0] t1;
  } timer_counts_t;
  typedef struct packed {
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [4:0] prevLvl;
    logic [4:0][3:0] presc;
    logic [7:0] tselLo;
    logic [7:0] tselHi;
    logic [4:0][3:0] mode;
    logic [1:0] route;
    logic [4:0] flags;
    logic [4:0] mask;
    logic [4:0][15:0] cap;
    logic [31:0] prdata;
    logic pready;
    logic irq;
  } ic_state_t;
endpackage

// ==== verilog/input_capture_unit.sv ====
`timescale 1ns/10ps
`include "input_capture_defs.svh"
module input_capture_unit (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire input_capture_pkg::timer_counts_t timerCounts,
  input wire logic [6:0] capturePins,
  output logic irq
);

  input_capture_pkg::ic_state_t state_q;
  input_capture_pkg::ic_state_t state_d;

  logic [4:0] lvl;
  logic [4:0] rise;
  logic [4:0] fall;
  logic [4:0] strobe;
  logic [4:0][15:0] pick;
  logic [4:0][1:0] tsel;
  logic [4:0] modeChanged;
  logic wrEn;
  logic rdEn;
  logic [31:0] rdMux;

  // Map a two-bit timer choice onto one count; code 3 falls back to the first
  function automatic logic [15:0] timerPick(input logic [1:0] sel,
                                            input input_capture_pkg::timer_counts_t t);
    logic [15:0] r;
    r = t.t1;
    if (sel == 2'h1) begin
      r = t.t3;
    end else if (sel == 2'h2) begin
      r = t.t5;
    end
    return r;
  endfunction

  // Capture-value register index of a byte address, or 3'h7 when none
  function automatic logic [2:0] capIndex(input logic [11:0] a);
    logic [11:0] rel;
    logic [2:0] r;
    rel = a - `IC_OFF_CAP0;
    r = 3'h7;
    if (a >= `IC_OFF_CAP0 && rel[1:0] == 2'h0 && rel[11:2] < 10'h005) begin
      r = rel[4:2];
    end
    return r;
  endfunction

  // Per-channel timer choice fields
  assign tsel[0] = state_q.tselLo[1:0];
  assign tsel[1] = state_q.tselLo[4:3];
  assign tsel[2] = state_q.tselLo[7:6];
  assign tsel[3] = state_q.tselHi[1:0];
  assign tsel[4] = state_q.tselHi[3:2];

  // Pin routing; pins 0..6 are ch1, ch2 alt0/alt1, ch3 alt0/alt1, ch4, ch5
  always_comb begin
    lvl[0] = state_q.sync2[0];
    lvl[1] = state_q.route[0] ? state_q.sync2[2] : state_q.sync2[1];
    lvl[2] = state_q.route[1] ? state_q.sync2[4] : state_q.sync2[3];
    lvl[3] = state_q.sync2[5];
    lvl[4] = state_q.sync2[6];
  end

  // Edge detection on the routed pin level against its level one cycle earlier
  assign rise = lvl & ~state_q.prevLvl;
  assign fall = ~lvl & state_q.prevLvl;

  assign wrEn = psel && penable && pwrite && !state_q.pready;
  assign rdEn = psel && penable && !pwrite && !state_q.pready;

  // Event qualification per mode; unused codes leave the channel idle
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pick[i] = timerPick(tsel[i], timerCounts);
      unique case (state_q.mode[i])
        `IC_MODE_FALL: strobe[i] = fall[i];
        `IC_MODE_RISE: strobe[i] = rise[i];
        `IC_MODE_RISE4: strobe[i] = rise[i] && state_q.presc[i] == `IC_PRESC4_END;
        `IC_MODE_RISE16: strobe[i] = rise[i] && state_q.presc[i] == `IC_PRESC16_END;
        default: strobe[i] = 1'b0;
      endcase
      modeChanged[i] = wrEn && paddr == `IC_OFF_MODE
                       && pwdata[i*4 +: 4] != state_q.mode[i];
    end
  end

  // Read multiplexer; unmapped reads return zero and pslverr stays low
  always_comb begin
    rdMux = 32'h0000_0000;
    case (paddr)
      `IC_OFF_TSEL_LO: rdMux = {24'h00_0000, state_q.tselLo};
      `IC_OFF_TSEL_HI: rdMux = {24'h00_0000, state_q.tselHi};
      `IC_OFF_MODE: rdMux = {12'h000, state_q.mode};
      `IC_OFF_ROUTE: rdMux = {30'h0000_0000, state_q.route};
      `IC_OFF_FLAGS: rdMux = {27'h000_0000, state_q.flags};
      `IC_OFF_MASK: rdMux = {27'h000_0000, state_q.mask};
      default: begin
        if (capIndex(paddr) != 3'h7) begin
          rdMux = {16'h0000, state_q.cap[capIndex(paddr)]};
        end
      end
    endcase
  end

  // Next-state logic for the whole block
  always_comb begin
    state_d = state_q;
    state_d.sync1 = capturePins;
    state_d.sync2 = state_q.sync1;
    state_d.prevLvl = lvl;
    state_d.pready = psel && penable && !state_q.pready;
    if (rdEn) begin
      state_d.prdata = rdMux;
    end
    // Register writes; reserved bits are not stored
    if (wrEn) begin
      case (paddr)
        `IC_OFF_TSEL_LO: state_d.tselLo = pwdata[7:0] & 8'hdb;
        `IC_OFF_TSEL_HI: state_d.tselHi = pwdata[7:0] & 8'h0f;
        `IC_OFF_MODE: state_d.mode = pwdata[19:0];
        `IC_OFF_ROUTE: state_d.route = pwdata[1:0];
        `IC_OFF_MASK: state_d.mask = pwdata[4:0];
        default: ;
      endcase
    end
    for (int i = 0; i < 5; i++) begin
      // Prescaler counts rising edges in the every-fourth and every-sixteenth modes and restarts on a mode change
      if (modeChanged[i]) begin
        state_d.presc[i] = 4'h0;
      end else if (rise[i]) begin
        if (state_q.mode[i] == `IC_MODE_RISE4 || state_q.mode[i] == `IC_MODE_RISE16) begin
          state_d.presc[i] = strobe[i] ? 4'h0 : state_q.presc[i] + 4'h1;
        end
      end
      // Latest capture always wins; there is no overrun protection
      if (strobe[i]) begin
        state_d.cap[i] = pick[i];
      end
    end
    // Flags clear on read, but an event in the same cycle still sets
    if (rdEn && paddr == `IC_OFF_FLAGS) begin
      state_d.flags = strobe;
    end else begin
      state_d.flags = state_q.flags | strobe;
    end
    state_d.irq = |(state_d.flags & state_d.mask);
  end

  // Single state register with synchronous reset
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= '0;
      state_q.route <= `IC_ROUTE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  assign prdata = state_q.prdata;
  assign pready = state_q.pready;
  assign pslverr = 1'b0;
  assign irq = state_q.irq;

  // Checks are silenced while reset is held; each one guards one behaviour above
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Time base choice: each code must reach the channel that selects it
  chk_timer_pick: assert property (strobe[1] && tsel[1] == 2'h2 |=>
      state_q.cap[1] == $past(timerCounts.t5))
    else $error("channel 2 did not take timer five");

  chk_timer_mid: assert property (strobe[1] && tsel[1] == 2'h1 |=>
      state_q.cap[1] == $past(timerCounts.t3))
    else $error("channel 2 did not take timer three");

  chk_timer_low: assert property (strobe[0] && tsel[0] == 2'h0 |=>
      state_q.cap[0] == $past(timerCounts.t1))
    else $error("channel 1 did not take timer one");

  // The spare code falls back to the first timer rather than capturing garbage
  chk_timer_spare: assert property (strobe[2] && tsel[2] == 2'h3 |=>
      state_q.cap[2] == $past(timerCounts.t1))
    else $error("spare timer code did not fall back to timer one");

  chk_capture_value: assert property (strobe[0] |=>
      state_q.cap[0] == $past(pick[0]))
    else $error("captured value differs from timer count");

  // Without a qualifying event the stored value must not move
  chk_cap_hold: assert property (!strobe[4] |=> $stable(state_q.cap[4]))
    else $error("capture value changed without an event");

  chk_fall_mode: assert property (state_q.mode[2] == `IC_MODE_FALL && fall[2] |->
      strobe[2] ##1 state_q.flags[2])
    else $error("falling edge did not capture");

  chk_fall_only: assert property (state_q.mode[2] == `IC_MODE_FALL && rise[2] |->
      !strobe[2])
    else $error("falling mode reacted to a rising edge");

  chk_rise_not_fall: assert property (state_q.mode[3] == `IC_MODE_RISE |->
      strobe[3] == rise[3])
    else $error("rising mode reacted to wrong edge");

  // Codes outside the four capture modes leave the channel idle
  chk_idle_mode: assert property (!(state_q.mode[4] inside {`IC_MODE_FALL,
      `IC_MODE_RISE, `IC_MODE_RISE4, `IC_MODE_RISE16}) |-> !strobe[4])
    else $error("channel captured in an idle mode");

  chk_flag_sticky: assert property (state_q.flags[0] &&
      !(rdEn && paddr == `IC_OFF_FLAGS) |=> state_q.flags[0])
    else $error("flag cleared without a read");

  // Read-to-clear must not swallow an event landing in the same cycle
  chk_set_wins: assert property (strobe[2] |=> state_q.flags[2])
    else $error("capture event did not set its flag");

  chk_flag_clear: assert property (rdEn && paddr == `IC_OFF_FLAGS && !strobe[1] |=>
      !state_q.flags[1])
    else $error("flag survived a read of the flag register");

  chk_overwrite: assert property (strobe[4] ##[1:20] strobe[4] |=>
      state_q.cap[4] == $past(pick[4]))
    else $error("second capture did not overwrite");

  // Routing bits pick the pin, whatever level the other pin shows
  chk_route_two: assert property (state_q.route[0] |-> lvl[1] == state_q.sync2[2])
    else $error("channel 2 routed from wrong pin");

  chk_route_two_alt: assert property (!state_q.route[0] |-> lvl[1] == state_q.sync2[1])
    else $error("channel 2 alternate routed from wrong pin");

  chk_route_three: assert property (state_q.route[1] |-> lvl[2] == state_q.sync2[4])
    else $error("channel 3 routed from wrong pin");

  chk_route_three_alt: assert property (!state_q.route[1] |-> lvl[2] == state_q.sync2[3])
    else $error("channel 3 default routed from wrong pin");

  chk_mode_restart: assert property (modeChanged[1] |=> state_q.presc[1] == 4'h0)
    else $error("prescaler not restarted on mode change");

  // Prescaler restarts once the fourth edge has been taken
  chk_presc_four: assert property (strobe[0] && state_q.mode[0] == `IC_MODE_RISE4 |=>
      state_q.presc[0] == 4'h0 && state_q.flags[0])
    else $error("every-fourth capture did not restart the prescaler");

  // In every-fourth mode the count can never run past its terminal value
  chk_presc_bound: assert property (state_q.mode[0] == `IC_MODE_RISE4 |->
      state_q.presc[0] <= `IC_PRESC4_END)
    else $error("every-fourth prescaler ran past its end");

  chk_presc_step: assert property (rise[0] && state_q.mode[0] == `IC_MODE_RISE4 &&
      !strobe[0] && !modeChanged[0] |=> state_q.presc[0] == $past(state_q.presc[0]) + 4'h1)
    else $error("prescaler did not count a rising edge");

  chk_presc_idle: assert property (!rise[3] && !modeChanged[3] |=>
      $stable(state_q.presc[3]))
    else $error("prescaler moved without a rising edge");

  chk_presc_sixteen: assert property (strobe[3] &&
      state_q.mode[3] == `IC_MODE_RISE16 |=> state_q.presc[3] == 4'h0 && state_q.flags[3])
    else $error("every-sixteenth capture did not restart the prescaler");

  chk_pin_sync: assert property ($rose(capturePins[0]) ##1 capturePins[0] [*2] |=>
      state_q.sync2[0])
    else $error("pin level not through two stages");

  // Bus side: ready is a single-cycle answer and mode writes land whole
  chk_ready_pulse: assert property (state_q.pready |=> !state_q.pready)
    else $error("ready stood for more than one cycle");

  chk_mode_write: assert property (wrEn && paddr == `IC_OFF_MODE |=>
      state_q.mode == $past(pwdata[19:0]))
    else $error("mode write not stored");

  chk_irq_level: assert property (irq == |(state_q.flags & state_q.mask))
    else $error("interrupt does not follow masked flags");

endmodule

// ==== verification/pin_source.sv ====
`timescale 1ns/10ps
// Far-side source: shows the requested pin levels one edge later,
// as an outside driver on an input pin would
module pin_source (
  input wire logic clk,
  input wire logic [6:0] want,
  output logic [6:0] capturePins
);
  // Pins stay inputs of the unit; only this source drives them
  always_ff @(posedge clk) begin
    capturePins <= want;
  end
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
`include "input_capture_defs.svh"
module testbench;
  logic clk = 0;
  logic reset = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq;
  input_capture_pkg::timer_counts_t timerCounts = '0;
  logic [6:0] want = 7'h00;
  logic [6:0] capturePins;
  logic [31:0] seed = 32'hf638ec9a;
  int n_mismatch = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  pin_source src (.clk(clk), .want(want), .capturePins(capturePins));
  input_capture_unit dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timerCounts(timerCounts), .capturePins(capturePins), .irq(irq));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic summarize();
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) chk("pready", 32'h1, 32'h0);
    r = prdata;
    chk("pslverr", 32'h0, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // New timer counts and a pin level at the same edge; returns the chosen count
  task automatic pinStep(input int p, input logic v, input logic [1:0] c,
                      output logic [15:0] t);
    logic [31:0] a, b;
    a = rnd();
    b = rnd();
    @(posedge clk);
    timerCounts <= {a[15:0], b};
    want[p] <= v;
    t = (c == 2'h1) ? b[31:16] : (c == 2'h2) ? a[15:0] : b[15:0];
    repeat (6) @(posedge clk);
  endtask

  // Model of one channel: which edges capture, what is kept, what is flagged
  task automatic run(input int ch, input logic [3:0] md, input int pulses, input logic [1:0] rt);
    int div, p;
    logic [31:0] r;
    logic [1:0] c;
    logic [15:0] t;
    logic q;
    logic [15:0] capQ[$];
    div = (md == `IC_MODE_RISE4) ? 4 : (md == `IC_MODE_RISE16) ? 16 : 1;
    p = (ch == 0) ? 0 : (ch == 1) ? 1 + rt[0] : (ch == 2) ? 3 + rt[1] : ch + 2;
    // Timer code steps with channel and mode, so every code and every timer is used
    c = 2'(ch) + md[1:0];
    apb(1'b1, `IC_OFF_ROUTE, {30'h0, rt}, r);
    apb(1'b1, `IC_OFF_TSEL_LO, {24'h0, c, 1'b0, c, 1'b0, c}, r);
    apb(1'b1, `IC_OFF_TSEL_HI, {28'h0, c, c}, r);
    apb(1'b1, `IC_OFF_MASK, {27'h0, 5'(ch[0]) << ch}, r);
    apb(1'b1, `IC_OFF_MODE, 32'(md) << (4 * ch), r);
    apb(1'b0, `IC_OFF_FLAGS, 32'h0, r);
    for (int i = 1; i <= pulses; i++) begin
      q = (i % div == 0);
      pinStep(p, 1'b1, c, t);
      if (q && md != `IC_MODE_FALL) capQ.push_back(t);
      pinStep(p, 1'b0, c, t);
      if (q && md == `IC_MODE_FALL) capQ.push_back(t);
      chk("irq", {31'h0, q & ch[0]}, {31'h0, irq});
      apb(1'b0, `IC_OFF_FLAGS, 32'h0, r);
      chk("flags", {27'h0, 5'(q) << ch}, r);
    end
    apb(1'b0, `IC_OFF_CAP0 + 12'(4 * ch), 32'h0, r);
    chk("capture", {16'h0, capQ[$]}, r);
  endtask

  // Hang guard, well beyond the expected 1300 or so cycles
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a <= 'h28; a += 4) begin
      apb(1'b0, 12'(a), 32'h0, rd);
      chk("reset value", (a == 'hc) ? 32'h1 : 32'h0, rd);
    end
    apb(1'b1, 12'h02c, 32'hffffffff, rd);
    apb(1'b0, 12'h02c, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    for (int ch = 0; ch < 5; ch++)
      for (int m = 4; m < 6; m++) run(ch, 4'(m), 2, 2'h1);
    run(1, `IC_MODE_RISE, 2, 2'h2);
    run(2, `IC_MODE_FALL, 2, 2'h2);
    run(0, `IC_MODE_RISE4, 8, 2'h1);
    run(3, `IC_MODE_RISE16, 16, 2'h1);
    summarize();
  end
endmodule
